// File: rtl/codec_power_audio_control_regs.v
/*
  AXI4-Lite slave holding the codec power control and audio control 3
  registers, with decoded control outputs. Assumes status inputs and
  saturation pulses synchronous to clk; one access of each kind at a time.
*/
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`include "codec_regs_map.vh"
module codec_power_audio_control_regs
#(
  parameter [2:0] REVISION = 3'h1 // Arbitrary value
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        record_pd_done,
  input  wire        left_play_pd_done,
  input  wire        right_play_pd_done,
  input  wire        sidetone_pd_done,
  input  wire        record_sat,
  input  wire        left_play_sat,
  input  wire        right_play_sat,
  input  wire        agc_selected,
  input  wire [7:0]  left_vol_prog,
  input  wire [7:0]  right_vol_prog,
  output reg         handset_mic_bias_pd,
  output reg         headset_mic_bias_pd,
  output reg         sidetone_pd,
  output reg         speaker_one_pd,
  output reg         speaker_two_pd,
  output reg         playback_conv_pd,
  output reg         record_conv_pd,
  output reg         virtual_ground_pd,
  output reg         phone_out_pd,
  output reg         loudspeaker_pd,
  output reg         codec_all_pd,
  output reg         effects_filter_en,
  output reg         deemphasis_en,
  output reg         ref_rate_sel,
  output reg         transfer_mode_sel,
  output reg         port_role_sel,
  output reg         phone_in_diff_sel,
  output reg         phone_out_diff_sel,
  output reg         clip_step_active,
  output reg  [7:0]  left_vol_eff,
  output reg  [7:0]  right_vol_eff
);

  reg  [15:0] power_reg;
  reg  [15:0] audio3_reg;
  reg         aw_held_reg;
  reg  [7:0]  aw_addr_reg;
  reg         w_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  wire [2:0]  ovf_flags;
  wire        ovf_clear;
  wire [7:0]  left_vol_mux;
  wire [7:0]  right_vol_mux;
  wire [15:0] power_view;
  wire [15:0] audio3_view;
  wire        do_write;
  wire        do_read;

  function [15:0] merge_bytes;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  strb;
    input [15:0] mask;
    reg   [15:0] lanes;
    begin
      lanes       = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      merge_bytes = (old_val & ~lanes) | (new_val & lanes);
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `POWER_CTRL_ADDR) || (addr == `AUDIO_CTRL3_ADDR);
    end
  endfunction

  assign power_view  = {power_reg[`PD_HI:`PD_LO], record_pd_done, left_play_pd_done, // RULE8 RULE9
                        right_play_pd_done, sidetone_pd_done, power_reg[1:0]};          // RULE10
  assign audio3_view = {audio3_reg[15:9], ovf_flags, audio3_reg[5:3], REVISION};      // RULE22
  assign do_write    = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign do_read     = s_axi_arvalid && s_axi_arready;
  // Only a read of audio control 3 clears its flags
  assign ovf_clear   = do_read && (s_axi_araddr == `AUDIO_CTRL3_ADDR); // RULE19 RULE20

  overflow_flags u_flags
  (
    .clk       (clk),
    .rst       (rst),
    .event_in  ({record_sat, left_play_sat, right_play_sat}),
    .rd_clear  (ovf_clear),
    .flags_reg (ovf_flags)
  );

  volume_link u_vol
  (
    .link_sel      (audio3_reg[`VOL_HI:`VOL_LO]),
    .left_vol_in   (left_vol_prog),
    .right_vol_in  (right_vol_prog),
    .left_vol_out  (left_vol_mux),
    .right_vol_out (right_vol_mux)
  );

  // Write address and data are captured independently, in either order
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_held_reg    <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Write masks keep read-only bits out of storage; reserved bits are plain storage
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      power_reg  <= `POWER_RESET;  // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE11 RULE12
      audio3_reg <= `AUDIO3_RESET; // RULE15 RULE16 RULE17 RULE18 RULE21
    end
    else if (do_write)
    begin
      if (aw_addr_reg == `POWER_CTRL_ADDR)
        power_reg <= merge_bytes(power_reg, w_data_reg[15:0], w_strb_reg[1:0], `POWER_WR_MASK); // RULE23
      if (aw_addr_reg == `AUDIO_CTRL3_ADDR)
        audio3_reg <= merge_bytes(audio3_reg, w_data_reg[15:0], w_strb_reg[1:0], `AUDIO3_WR_MASK); // RULE23
    end
  end

  // Read channel: one read at a time, answered the cycle after acceptance
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (do_read)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
          `POWER_CTRL_ADDR:  s_axi_rdata <= {16'h0000, power_view};
          `AUDIO_CTRL3_ADDR: s_axi_rdata <= {16'h0000, audio3_view};
          default:           s_axi_rdata <= 32'h00000000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Control outputs registered, one cycle behind the register contents
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      handset_mic_bias_pd <= 1'b1;
      headset_mic_bias_pd <= 1'b1;
      sidetone_pd         <= 1'b1;
      speaker_one_pd      <= 1'b1;
      speaker_two_pd      <= 1'b1;
      playback_conv_pd    <= 1'b1;
      record_conv_pd      <= 1'b1;
      virtual_ground_pd   <= 1'b1;
      phone_out_pd        <= 1'b1;
      loudspeaker_pd      <= 1'b1;
      codec_all_pd        <= 1'b1;
      effects_filter_en   <= 1'b0;
      deemphasis_en       <= 1'b0;
      ref_rate_sel        <= 1'b0;
      transfer_mode_sel   <= 1'b0;
      port_role_sel       <= 1'b0;
      phone_in_diff_sel   <= 1'b0;
      phone_out_diff_sel  <= 1'b0;
      clip_step_active    <= 1'b0;
      left_vol_eff        <= 8'h00;
      right_vol_eff       <= 8'h00;
    end
    else
    begin
      handset_mic_bias_pd <= power_reg[15];                              // RULE1
      headset_mic_bias_pd <= power_reg[14];                              // RULE1
      sidetone_pd         <= power_reg[13];                              // RULE2
      speaker_one_pd      <= power_reg[12];                              // RULE3
      speaker_two_pd      <= power_reg[11];                              // RULE3
      playback_conv_pd    <= power_reg[10];                              // RULE4
      record_conv_pd      <= power_reg[9];                               // RULE4
      virtual_ground_pd   <= power_reg[8];                               // RULE5
      phone_out_pd        <= power_reg[7];                               // RULE6
      loudspeaker_pd      <= power_reg[6];                               // RULE3
      codec_all_pd        <= &power_reg[`PD_HI:`PD_LO];                  // RULE7
      effects_filter_en   <= power_reg[`BIT_EFFECTS];                    // RULE11
      deemphasis_en       <= power_reg[`BIT_DEEMPH];                     // RULE12
      ref_rate_sel        <= audio3_reg[`BIT_REF_RATE];                  // RULE14
      transfer_mode_sel   <= audio3_reg[`BIT_XFER_MODE];                 // RULE15
      port_role_sel       <= audio3_reg[`BIT_PORT_ROLE];                 // RULE16
      phone_in_diff_sel   <= audio3_reg[`BIT_PHONE_IN_DIFF];             // RULE17
      phone_out_diff_sel  <= audio3_reg[`BIT_PHONE_OUT_DIFF];            // RULE18
      clip_step_active    <= audio3_reg[`BIT_CLIP_STEP] && agc_selected; // RULE21
      left_vol_eff        <= left_vol_mux;                               // RULE13
      right_vol_eff       <= right_vol_mux;                              // RULE13
    end
  end

endmodule // codec_power_audio_control_regs

// File: rtl/codec_regs_map.vh
/*
  Register offsets, field positions, reset values for the codec power and
  audio control register pair. Assumes inclusion by bare name from rtl/.
*/
// Summary of operation
// RULE1 - Bits 15 and 14 power down handset and headset mic bias; reset 1.
// RULE2 - Bit 13 powers down the analog sidetone path; reset 1.
// RULE3 - Bits 12, 11 and 6 power down speaker one, two and loudspeaker; reset 1.
// RULE4 - Bit 10 powers down playback converter, bit 9 record converter; reset 1.
// RULE5 - Bit 8 powers down the driver virtual ground; reset 1.
// RULE6 - Bit 7 powers down the phone-module output; reset 1.
// RULE7 - All ten power-down bits set means the whole codec is powered down.
// RULE8 - Read-only bit 5 shows record converter power-down done; reset 1.
// RULE9 - Read-only bits 4 and 3 show left and right playback power-down done.
// RULE10 - Read-only bit 2 shows sidetone power-down done; reset 1.
// RULE11 - Bit 1 enables the effects filter on playback; reset 0.
// RULE12 - Bit 0 enables the de-emphasis filter; reset 0.
// RULE13 - Volume link code 01 left follows right, 10 right follows left, else independent.
// RULE14 - Bit 13 selects 48.0 kHz when 0, 44.1 kHz when 1.
// RULE15 - Bit 12 selects continuous transfer at 0, 256-sample burst at 1.
// RULE16 - Bit 11 makes the serial port slave at 0, master at 1.
// RULE17 - Bit 10 selects differential phone input when 1.
// RULE18 - Bit 9 selects differential phone output when 1.
// RULE19 - Record overflow flag bit 8 sets on saturation, cleared by reading.
// RULE20 - Left and right playback overflow flags bits 7 and 6, cleared by read.
// RULE21 - Clip stepping bit 3 acts only while mic gain control is automatic.
// RULE22 - Read-only three-bit revision field in bits 2 to 0.
// RULE23 - Writes to read-only bits ignored; reserved bits 5 and 4 stored only.
`ifndef CODEC_REGS_MAP_VH
`define CODEC_REGS_MAP_VH
`define POWER_CTRL_INDEX   8'h05
`define AUDIO_CTRL3_INDEX  8'h06
`define POWER_CTRL_ADDR    8'h14
`define AUDIO_CTRL3_ADDR   8'h18
`define POWER_WR_MASK      16'hFFC3
`define POWER_RESET        16'hFFFC
`define AUDIO3_WR_MASK     16'hFE38
`define AUDIO3_RESET       16'h0000
`define PD_HI              15
`define PD_LO              6
`define PD_DONE_REC        5
`define PD_DONE_LEFT       4
`define PD_DONE_RIGHT      3
`define PD_DONE_SIDE       2
`define BIT_EFFECTS        1
`define BIT_DEEMPH         0
`define VOL_HI             15
`define VOL_LO             14
`define VOL_LEFT_FOLLOWS   2'h1
`define VOL_RIGHT_FOLLOWS  2'h2
`define BIT_REF_RATE       13
`define BIT_XFER_MODE      12
`define BIT_PORT_ROLE      11
`define BIT_PHONE_IN_DIFF  10
`define BIT_PHONE_OUT_DIFF 9
`define BIT_OVF_REC        8
`define BIT_OVF_LEFT       7
`define BIT_OVF_RIGHT      6
`define BIT_CLIP_STEP      3
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// File: rtl/overflow_flags.v
/*
  Sticky overflow flags, set by saturation pulses, cleared by a read.
  Assumes rd_clear is a one-cycle pulse at the accepted read.
*/
`timescale 1ns/100ps
module overflow_flags
(
  input  wire       clk,
  input  wire       rst,
  input  wire [2:0] event_in,
  input  wire       rd_clear,
  output reg  [2:0] flags_reg
);
  // A saturation arriving with the read clearing survives for the next read
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      flags_reg <= 3'h0;
    else
      flags_reg <= (rd_clear ? 3'h0 : flags_reg) | event_in; // RULE19 RULE20
  end
endmodule // overflow_flags

// File: rtl/volume_link.v
/*
  Volume link decode: picks the effective left and right volume codes.
  Assumes 8-bit programmed volumes from the codec volume registers.
*/
`timescale 1ns/100ps
`include "codec_regs_map.vh"
module volume_link
(
  input  wire [1:0] link_sel,
  input  wire [7:0] left_vol_in,
  input  wire [7:0] right_vol_in,
  output reg  [7:0] left_vol_out,
  output reg  [7:0] right_vol_out
);
  always @*
  begin
    left_vol_out  = left_vol_in;
    right_vol_out = right_vol_in;
    case (link_sel) // RULE13
      `VOL_LEFT_FOLLOWS:  left_vol_out  = right_vol_in;
      `VOL_RIGHT_FOLLOWS: right_vol_out = left_vol_in;
      default:
      begin
        left_vol_out  = left_vol_in;
        right_vol_out = right_vol_in;
      end
    endcase
  end
endmodule // volume_link

// File: verification/codec_power_audio_control_regs_checker.sv
/*
  Bus and decode checker for the codec control register slave.
  Assumes one clock domain, asynchronous active-high reset, top-module ports only.
*/
`timescale 1ns/100ps
module codec_regs_checker
(
  input wire        clk,
  input wire        rst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        agc_selected,
  input wire        clip_step_active,
  input wire [7:0]  left_vol_prog,
  input wire [7:0]  right_vol_prog,
  input wire [7:0]  left_vol_eff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  clip_gate_a: assert property (clip_step_active |-> $past(agc_selected))
    else $error("clip stepping without gain control");
  // The first edge after reset still shows the reset value, not a programmed one
  vol_source_a: assert property (!$past(rst) |-> left_vol_eff == $past(left_vol_prog) || left_vol_eff == $past(right_vol_prog))
    else $error("left volume from no programmed value");
endmodule // codec_regs_checker

bind codec_power_audio_control_regs codec_regs_checker chk
(
  .clk              (clk),
  .rst              (rst),
  .s_axi_awvalid    (s_axi_awvalid),
  .s_axi_awready    (s_axi_awready),
  .s_axi_wvalid     (s_axi_wvalid),
  .s_axi_wready     (s_axi_wready),
  .s_axi_bresp      (s_axi_bresp),
  .s_axi_bvalid     (s_axi_bvalid),
  .s_axi_bready     (s_axi_bready),
  .s_axi_arvalid    (s_axi_arvalid),
  .s_axi_arready    (s_axi_arready),
  .s_axi_rdata      (s_axi_rdata),
  .s_axi_rvalid     (s_axi_rvalid),
  .s_axi_rready     (s_axi_rready),
  .agc_selected     (agc_selected),
  .clip_step_active (clip_step_active),
  .left_vol_prog    (left_vol_prog),
  .right_vol_prog   (right_vol_prog),
  .left_vol_eff     (left_vol_eff)
);

// File: verification/test_codec_power_audio_control_regs.sv
/*
  Self-checking bench for the codec control register slave.
  Drives its AXI4-Lite port and status inputs; the checker is bound to it.
*/
`timescale 1ns/100ps
module test_codec_power_audio_control_regs;
  localparam [7:0] PWR = 8'h14;
  localparam [7:0] AU3 = 8'h18;
  localparam [7:0] BAD = 8'h1C;
  localparam [2:0] REV = 3'h5; // Arbitrary revision value
  reg         clk, rst, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr, left_vol_prog, right_vol_prog;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg         record_pd_done, left_play_pd_done, right_play_pd_done, sidetone_pd_done;
  reg         record_sat, left_play_sat, right_play_sat, agc_selected;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        handset_mic_bias_pd, headset_mic_bias_pd, sidetone_pd, speaker_one_pd, speaker_two_pd;
  wire        playback_conv_pd, record_conv_pd, virtual_ground_pd, phone_out_pd, loudspeaker_pd;
  wire        codec_all_pd, effects_filter_en, deemphasis_en, ref_rate_sel, transfer_mode_sel;
  wire        port_role_sel, phone_in_diff_sel, phone_out_diff_sel, clip_step_active;
  wire [7:0]  left_vol_eff, right_vol_eff;
  wire [9:0]  pd_out = {handset_mic_bias_pd, headset_mic_bias_pd, sidetone_pd, speaker_one_pd, speaker_two_pd,
                        playback_conv_pd, record_conv_pd, virtual_ground_pd, phone_out_pd, loudspeaker_pd};
  wire [5:0]  au_out = {ref_rate_sel, transfer_mode_sel, port_role_sel, phone_in_diff_sel, phone_out_diff_sel,
                        clip_step_active};
  reg  [15:0] lfsr, d, e;
  integer     miscompares, compares, cycles, i;

  codec_power_audio_control_regs #(.REVISION(REV)) uut (.*);

  always #5 clk = ~clk;

  function [15:0] next_rand(input [15:0] v);
    next_rand = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function [15:0] vol_exp(input [1:0] c, input [7:0] l, input [7:0] r);
    vol_exp = (c == 2'h1) ? {r, r} : (c == 2'h2) ? {l, l} : {l, r};
  endfunction

  task chk(input [63:0] n, input [15:0] x, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== x)
      begin
        miscompares = miscompares + 1;
        $display("unexpected %0s expected %h seen %h", n, x, g);
      end
    end
  endtask

  // A slow master keeps ready low two cycles so the hold rules get exercised
  task wr(input [7:0] a, input [15:0] v, input [3:0] s, input [1:0] r);
    reg aw_ok, w_ok;
    begin
      aw_ok = 1'h0;
      w_ok = 1'h0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {~v, v};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= !slow;
      while (!(aw_ok && w_ok))
      begin
        @(posedge clk);
        aw_ok = aw_ok || s_axi_awready;
        w_ok = w_ok || s_axi_wready;
        s_axi_awvalid <= !aw_ok;
        s_axi_wvalid <= !w_ok;
      end
      if (slow)
        repeat (2) @(posedge clk);
      s_axi_bready <= 1'h1;
      @(posedge clk);
      while (!s_axi_bvalid) @(posedge clk);
      s_axi_bready <= 1'h0;
      chk("bresp", {14'h0, r}, {14'h0, s_axi_bresp});
    end
  endtask

  task rd(input [7:0] a, input [15:0] x, input [1:0] r);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= !slow;
      @(posedge clk);
      while (!s_axi_arready) @(posedge clk);
      s_axi_arvalid <= 1'h0;
      if (slow)
        repeat (2) @(posedge clk);
      s_axi_rready <= 1'h1;
      @(posedge clk);
      while (!s_axi_rvalid) @(posedge clk);
      s_axi_rready <= 1'h0;
      chk("rdata", x, s_axi_rdata[15:0]);
      chk("rresp", {14'h0, r}, {14'h0, s_axi_rresp});
    end
  endtask

  task stop_test;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end

  initial
  begin
    {clk, rst, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 8'h40;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {record_sat, left_play_sat, right_play_sat, agc_selected} = 4'h0;
    {record_pd_done, left_play_pd_done, right_play_pd_done, sidetone_pd_done} = 4'hF;
    {left_vol_prog, right_vol_prog} = 16'h3CA5;
    lfsr = 16'h18E5;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd(PWR, 16'hFFFC, 2'h0);
    rd(AU3, {13'h0, REV}, 2'h0);
    chk("pd", 16'h03FF, {6'h0, pd_out});
    chk("allpd", 16'h0001, {15'h0, codec_all_pd});
    $display("reset test done");
    for (i = 0; i < 10; i = i + 1)
    begin
      lfsr = next_rand(lfsr);
      d = (i == 0) ? 16'hFFFF : lfsr & {16{i != 1}};
      {record_pd_done, left_play_pd_done, right_play_pd_done, sidetone_pd_done} <= ~lfsr[5:2];
      wr(PWR, d, 4'hF, 2'h0);
      @(posedge clk);
      chk("pd", {6'h0, d[15:6]}, {6'h0, pd_out});
      chk("allpd", {15'h0, &d[15:6]}, {15'h0, codec_all_pd});
      chk("filter", {14'h0, d[1:0]}, {14'h0, effects_filter_en, deemphasis_en});
      rd(PWR, {d[15:6], ~lfsr[5:2], d[1:0]}, 2'h0);
    end
    $display("power test done");
    for (i = 0; i < 8; i = i + 1)
    begin
      lfsr = next_rand(lfsr);
      d = lfsr;
      if (i < 4)
        d[15:14] = i[1:0];
      slow <= i[0];
      agc_selected <= lfsr[4];
      left_vol_prog <= lfsr[7:0];
      right_vol_prog <= ~lfsr[7:0];
      wr(AU3, d, 4'hF, 2'h0);
      @(posedge clk);
      e = {d[15:9], 3'h0, d[5:3], REV};
      chk("ctrl", {10'h0, d[13:9], d[3] & agc_selected}, {10'h0, au_out});
      chk("vol", vol_exp(d[15:14], left_vol_prog, right_vol_prog), {left_vol_eff, right_vol_eff});
      rd(AU3, e, 2'h0);
    end
    $display("audio test done");
    for (i = 0; i < 3; i = i + 1)
    begin
      {record_sat, left_play_sat, right_play_sat} <= 3'h4 >> i;
      @(posedge clk);
      {record_sat, left_play_sat, right_play_sat} <= 3'h0;
      rd(AU3, e | (16'h0100 >> i), 2'h0);
      rd(AU3, e, 2'h0);
    end
    $display("overflow test done");
    wr(BAD, 16'hFFFF, 4'hF, 2'h2);
    rd(BAD, 16'h0000, 2'h2);
    {record_pd_done, left_play_pd_done, right_play_pd_done, sidetone_pd_done} <= 4'h5;
    wr(PWR, 16'hFFFF, 4'hF, 2'h0);
    wr(PWR, 16'h0000, 4'h2, 2'h0);
    rd(PWR, 16'h00D7, 2'h0);
    $display("bus test done");
    stop_test;
  end
endmodule // test_codec_power_audio_control_regs
